// ==== core/usp_defs.vh ====
// How it works
// - Seven, eight or nine data bits with one or two stop bits.
// - Synchronous mode as clock master or slave, phase select, free-running clock.
// - Nine-bit multidrop; software matches addresses and drives transceiver direction.
// - Odd, even or no parity generated on send and checked on receive.
// - One transmit holding word and one receive word, nothing deeper.
// - With flow control on, request-to-send driven and clear-to-send gates new starts.
// - Any change on clear-to-send while the port is enabled is flagged; a control holds off sending.
// - Received data and its status flags readable in one word.
// - Break sent on request; received break detected and each change flagged.
// - In asynchronous mode three samples per bit, majority vote, noise flag on any disagreement.
// - Bit rate from a baud generator fed by a shared fractional divider.
// - Ten interrupt sources, each enabled separately.
// - Data loopback and flow control loopback, selectable separately.
// - In asynchronous mode the baud clock can drive the serial clock pin.
// - Async rates up to 6.25 Mbit/s, sync up to 50 Mbit/s.
`ifndef USP_DEFS_VH
`define USP_DEFS_VH

`define USP_CFG        8'h00
`define USP_CTL        8'h04
`define USP_STAT       8'h08
`define USP_EVT        8'h0c
`define USP_MASK       8'h10
`define USP_RXDAT      8'h14
`define USP_RXDATSTAT  8'h18
`define USP_TXDAT      8'h1c
`define USP_BRG        8'h20
`define USP_FRG        8'h24

`define USP_CFG_EN     0
`define USP_CFG_LEN    2
`define USP_CFG_PAR    4
`define USP_CFG_STOP2  6
`define USP_CFG_CTSEN  9
`define USP_CFG_SYNC   11
`define USP_CFG_CLKPOL 12
`define USP_CFG_MSTR   14
`define USP_CFG_LOOPD  15
`define USP_CFG_LOOPF  16
`define USP_CFG_CLKOUT 17

`define USP_CTL_TXBRK  1
`define USP_CTL_TXDIS  6
`define USP_CTL_CC     9
`define USP_CTL_DIR    10

`define USP_ST_RXRDY   0
`define USP_ST_RXIDLE  1
`define USP_ST_TXRDY   2
`define USP_ST_TXIDLE  3
`define USP_ST_CTS     4
`define USP_ST_TXDIS   6
`define USP_ST_RXBRK   10

`define USP_EV_RXRDY   0
`define USP_EV_TXRDY   1
`define USP_EV_RXIDLE  2
`define USP_EV_DBRK    3
`define USP_EV_FRM     4
`define USP_EV_PAR     5
`define USP_EV_OVR     6
`define USP_EV_UND     7
`define USP_EV_DCTS    8
`define USP_EV_NOISE   9
`define USP_EV_W       10

`define USP_RS_FRM     13
`define USP_RS_PAR     14
`define USP_RS_NOISE   15

`define USP_CFG_RST    18'h00000
`define USP_CTL_RST    11'h000
`define USP_BRG_RST    16'h0000
`define USP_FRG_RST    8'h00
`define USP_OS_LAST    4'hf
`define USP_VOTE_A     4'h7
`define USP_VOTE_B     4'h8
`define USP_VOTE_C     4'h9

`endif

// ==== core/usp_frac_div.v ====
`timescale 1ns/1ps
// Rate = pclk / (1 + mult/256), tick may be shared by several ports
module usp_frac_div (
    input  wire       pclk,    // System clock
    input  wire       presetn, // Async reset, active low
    input  wire [7:0] mult,    // Fractional multiplier
    output reg        tick     // One-cycle rate pulse
);
    reg  [7:0] acc;
    reg        skip;
    wire [8:0] sum = {1'b0, acc} + {1'b0, mult};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc  <= 8'h00;
            skip <= 1'b0;
            tick <= 1'b0;
        end else if (skip) begin
            skip <= 1'b0;
            tick <= 1'b0;
        end else begin
            acc  <= sum[7:0];
            skip <= sum[8];
            tick <= 1'b1;
        end
    end
endmodule

// ==== core/usp_serial_port.v ====
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "usp_defs.vh"
module usp_serial_port (
    input  wire        pclk,       // System clock, 100 MHz
    input  wire        presetn,    // Async reset, active low
    input  wire [7:0]  paddr,      // APB byte address
    input  wire        psel,       // APB select
    input  wire        penable,    // APB enable
    input  wire        pwrite,     // APB write
    input  wire [31:0] pwdata,     // APB write data
    output reg         pready,     // APB ready
    output reg  [31:0] prdata,     // APB read data
    output reg         pslverr,    // APB error, unmapped address
    input  wire        rxd_i,      // Serial receive pin
    output reg         txd_o,      // Serial transmit pin
    input  wire        cts_n_i,    // Clear-to-send, active low
    output reg         rts_n_o,    // Request-to-send, active low
    input  wire        sclk_i,     // Serial clock pin in
    output reg         sclk_o,     // Serial clock pin out
    output reg         sclk_oe,    // Serial clock pin enable
    output reg         dir_o,      // RS-485 transceiver direction
    output reg         irq,        // Interrupt, level
    output wire        frg_tick_o  // Shared fractional rate tick
);
    function [3:0] nbits;
        input [1:0] l;
        nbits = (l == 2'd0) ? 4'd7 : (l == 2'd1) ? 4'd8 : 4'd9;
    endfunction

    function [8:0] dmask;
        input [3:0] n;
        dmask = 9'h1ff >> (4'd9 - n);
    endfunction

    reg  [17:0] cfg;
    reg  [10:0] ctl;
    reg  [15:0] brg;
    reg  [7:0]  frg;
    reg  [`USP_EV_W-1:0] evt;
    reg  [`USP_EV_W-1:0] mask;
    reg  [2:0]  sy1;
    reg  [2:0]  sy2;
    reg         sck3;
    reg  [15:0] brg_cnt;
    reg         brg_tick;
    reg  [8:0]  tx_buf;
    reg         tx_full;
    reg  [12:0] tx_sh;
    reg  [3:0]  tx_left;
    reg         tx_busy;
    reg  [3:0]  tx_os;
    reg  [11:0] rx_sh;
    reg  [3:0]  rx_bit;
    reg         rx_busy;
    reg  [3:0]  rx_os;
    reg         smp_a;
    reg         smp_b;
    reg         rx_nz;
    reg  [8:0]  rx_data;
    reg         rx_frm;
    reg         rx_perr;
    reg         rx_noise;
    reg         rx_full;
    reg         brk;
    reg         cts_q;
    reg  [`USP_EV_W-1:0] ev_set;
    reg  [31:0] rd_val;
    reg         rd_hit;

    wire frg_tick;
    usp_frac_div u_frac (
        .pclk    (pclk),
        .presetn (presetn),
        .mult    (frg),
        .tick    (frg_tick)
    );
    assign frg_tick_o = frg_tick;

    wire en      = cfg[`USP_CFG_EN];
    wire sync    = cfg[`USP_CFG_SYNC];
    wire mstr    = cfg[`USP_CFG_MSTR];
    wire clkpol  = cfg[`USP_CFG_CLKPOL];
    wire ctsen   = cfg[`USP_CFG_CTSEN];
    wire par_en  = cfg[`USP_CFG_PAR+1];
    wire par_odd = cfg[`USP_CFG_PAR];
    wire [3:0] n_dat  = nbits(cfg[`USP_CFG_LEN +: 2]);
    wire [3:0] rx_len = n_dat + {3'b000, par_en} + 4'd2;
    wire [3:0] tx_len = rx_len + {3'b000, cfg[`USP_CFG_STOP2]};

    // Synchronised pins, first stage read only by second
    wire rxd_s  = sy2[0];
    wire cts_s  = sy2[1];
    wire sck_s  = sy2[2];
    wire rx_in  = cfg[`USP_CFG_LOOPD] ? txd_o : rxd_s;
    wire cts_hi = cfg[`USP_CFG_LOOPF] ? rts_n_o : cts_s;

    // APB
    wire acc_done = psel & penable & pready;
    wire wr       = acc_done & pwrite;
    wire rd       = acc_done & ~pwrite;

    // Sync clock edges
    wire m_run  = sync & mstr & en & (tx_busy | ctl[`USP_CTL_CC] | sclk_o);
    wire m_rise = brg_tick & m_run & ~sclk_o;
    wire m_fall = brg_tick & m_run & sclk_o;
    wire s_rise = sck_s & ~sck3;
    wire s_fall = ~sck_s & sck3;
    wire e_rise = mstr ? m_rise : s_rise;
    wire e_fall = mstr ? m_fall : s_fall;
    wire launch = sync & en & (clkpol ? e_rise : e_fall);
    wire samp   = sync & en & (clkpol ? e_fall : e_rise);

    // Transmit
    wire tx_step = sync ? launch : (brg_tick & tx_busy & tx_os == `USP_OS_LAST);
    wire tx_hold = ctl[`USP_CTL_TXDIS] | (ctsen & cts_hi);
    wire tx_go   = en & tx_full & ~tx_busy & ~tx_hold;
    wire [8:0]  tx_d    = tx_buf & dmask(n_dat);
    wire        tx_par  = par_odd ^ (^tx_d);
    wire [3:0]  par_pos = n_dat + 4'd1;
    wire [3:0]  stp_pos = par_pos + {3'b000, par_en};
    wire [12:0] tx_ones = 13'h1fff << stp_pos;
    wire [12:0] tx_frm  = tx_ones | ({3'b000, tx_d, 1'b0})
                        | ({12'h000, par_en & tx_par} << par_pos);

    // Receive
    wire vote    = (smp_a & smp_b) | (smp_a & rx_in) | (smp_b & rx_in);
    wire vote_nz = ~((smp_a == smp_b) & (smp_b == rx_in));
    wire rb_stb  = sync ? (samp & (rx_busy | (~rx_in & ~brk)))
                        : (brg_tick & rx_busy & rx_os == `USP_VOTE_C);
    wire rb_val  = sync ? rx_in : vote;
    wire [11:0] rx_word = {rb_val, rx_sh[11:1]};
    wire [11:0] rx_al   = rx_word >> (4'd12 - rx_len);
    wire [8:0]  rx_d    = rx_al[9:1] & dmask(n_dat);
    wire        rx_pbit = rx_al[par_pos];
    wire        rx_end  = rb_stb & (rx_bit == rx_len - 4'd1);
    wire        rx_pe   = par_en & ((^rx_d) ^ rx_pbit ^ par_odd);
    wire        rx_brk  = (rx_al == 12'h000);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1  <= 3'b111;
            sy2  <= 3'b111;
            sck3 <= 1'b1;
        end else begin
            sy1  <= {sclk_i, cts_n_i, rxd_i};
            sy2  <= sy1;
            sck3 <= sy2[2];
        end
    end

    // Baud generator on the fractional rate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brg_cnt  <= 16'h0000;
            brg_tick <= 1'b0;
        end else begin
            brg_tick <= 1'b0;
            if (frg_tick) begin
                if (brg_cnt == brg) begin
                    brg_cnt  <= 16'h0000;
                    brg_tick <= 1'b1;
                end else begin
                    brg_cnt <= brg_cnt + 16'h0001;
                end
            end
        end
    end

    // Serial clock pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_o  <= 1'b0;
            sclk_oe <= 1'b0;
        end else begin
            sclk_oe <= en & (sync ? mstr : cfg[`USP_CFG_CLKOUT]);
            if (sync) begin
                if (m_rise | m_fall)
                    sclk_o <= ~sclk_o;
            end else if (cfg[`USP_CFG_CLKOUT] & en) begin
                if (brg_tick)
                    sclk_o <= ~sclk_o;
            end else begin
                sclk_o <= 1'b0;
            end
        end
    end

    // Transmitter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh   <= 13'h1fff;
            tx_left <= 4'h0;
            tx_busy <= 1'b0;
            tx_os   <= 4'h0;
            txd_o   <= 1'b1;
        end else begin
            txd_o <= ~ctl[`USP_CTL_TXBRK] & (~tx_busy | tx_sh[0]);
            if (!en) begin
                tx_busy <= 1'b0;
            end else if (tx_go) begin
                tx_sh   <= tx_frm;
                tx_left <= tx_len;
                tx_busy <= 1'b1;
                tx_os   <= 4'h0;
            end else if (tx_busy) begin
                if (brg_tick & ~sync)
                    tx_os <= tx_os + 4'h1;
                if (tx_step) begin
                    tx_sh   <= {1'b1, tx_sh[12:1]};
                    tx_left <= tx_left - 4'h1;
                    if (tx_left == 4'h1)
                        tx_busy <= 1'b0;
                end
            end
        end
    end

    // Receiver
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sh   <= 12'h000;
            rx_bit  <= 4'h0;
            rx_busy <= 1'b0;
            rx_os   <= 4'h0;
            smp_a   <= 1'b1;
            smp_b   <= 1'b1;
            rx_nz   <= 1'b0;
            brk     <= 1'b0;
        end else if (!en) begin
            rx_busy <= 1'b0;
            rx_bit  <= 4'h0;
        end else begin
            if (brk & ~rx_busy & rx_in)
                brk <= 1'b0;
            if (~sync & brg_tick) begin
                if (~rx_busy & ~rx_in & ~brk) begin
                    rx_busy <= 1'b1;
                    rx_os   <= 4'h0;
                    rx_bit  <= 4'h0;
                    rx_nz   <= 1'b0;
                end else if (rx_busy) begin
                    rx_os <= rx_os + 4'h1;
                    if (rx_os == `USP_VOTE_A)
                        smp_a <= rx_in;
                    if (rx_os == `USP_VOTE_B)
                        smp_b <= rx_in;
                    if (rx_os == `USP_VOTE_C && vote_nz)
                        rx_nz <= 1'b1;
                end
            end
            if (rb_stb) begin
                rx_sh <= rx_word;
                if (rx_bit == 4'h0 && rb_val) begin
                    rx_busy <= 1'b0;
                end else if (rx_end) begin
                    rx_busy <= 1'b0;
                    rx_bit  <= 4'h0;
                    if (rx_brk)
                        brk <= 1'b1;
                end else begin
                    if (rx_bit == 4'h0 && sync)
                        rx_nz <= 1'b0;
                    rx_busy <= 1'b1;
                    rx_bit  <= rx_bit + 4'h1;
                end
            end
        end
    end

    // Event sources
    always @* begin
        ev_set = {`USP_EV_W{1'b0}};
        ev_set[`USP_EV_RXRDY]  = rx_end & ~rx_full;
        ev_set[`USP_EV_TXRDY]  = tx_go;
        ev_set[`USP_EV_RXIDLE] = rx_end;
        ev_set[`USP_EV_DBRK]   = (rx_end & rx_brk & ~brk) | (brk & ~rx_busy & rx_in);
        ev_set[`USP_EV_FRM]    = rx_end & ~rb_val;
        ev_set[`USP_EV_PAR]    = rx_end & rx_pe;
        ev_set[`USP_EV_OVR]    = rx_end & rx_full;
        ev_set[`USP_EV_UND]    = sync & ~mstr & launch & ~tx_busy & ~tx_full & rx_busy;
        ev_set[`USP_EV_DCTS]   = en & (cts_hi != cts_q);
        ev_set[`USP_EV_NOISE]  = rx_end & (rx_nz | (~sync & vote_nz));
    end

    // Receive holding word, single entry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data  <= 9'h000;
            rx_frm   <= 1'b0;
            rx_perr  <= 1'b0;
            rx_noise <= 1'b0;
            rx_full  <= 1'b0;
            cts_q    <= 1'b1;
            rts_n_o  <= 1'b1;
            dir_o    <= 1'b0;
        end else begin
            cts_q   <= cts_hi;
            rts_n_o <= ctsen ? rx_full : 1'b0;
            dir_o   <= ctl[`USP_CTL_DIR];
            if (rx_end & ~rx_full) begin
                rx_data  <= rx_d;
                rx_frm   <= ~rb_val;
                rx_perr  <= rx_pe;
                rx_noise <= ev_set[`USP_EV_NOISE];
                rx_full  <= 1'b1;
            end else if (rd && (paddr == `USP_RXDAT || paddr == `USP_RXDATSTAT)) begin
                rx_full <= 1'b0;
            end
        end
    end

    // Read mux
    always @* begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case (paddr)
            `USP_CFG:       rd_val = {14'h0000, cfg};
            `USP_CTL:       rd_val = {21'h000000, ctl};
            `USP_STAT: begin
                rd_val[`USP_ST_RXRDY]  = rx_full;
                rd_val[`USP_ST_RXIDLE] = ~rx_busy;
                rd_val[`USP_ST_TXRDY]  = ~tx_full;
                rd_val[`USP_ST_TXIDLE] = ~tx_busy & ~tx_full;
                rd_val[`USP_ST_CTS]    = ~cts_hi;
                rd_val[`USP_ST_TXDIS]  = ctl[`USP_CTL_TXDIS] & ~tx_busy;
                rd_val[`USP_ST_RXBRK]  = brk;
            end
            `USP_EVT:       rd_val = {22'h000000, evt};
            `USP_MASK:      rd_val = {22'h000000, mask};
            `USP_RXDAT:     rd_val = {23'h000000, rx_data};
            `USP_RXDATSTAT: begin
                rd_val[8:0]            = rx_data;
                rd_val[`USP_RS_FRM]    = rx_frm;
                rd_val[`USP_RS_PAR]    = rx_perr;
                rd_val[`USP_RS_NOISE]  = rx_noise;
            end
            `USP_TXDAT:     rd_val = {23'h000000, tx_buf};
            `USP_BRG:       rd_val = {16'h0000, brg};
            `USP_FRG:       rd_val = {24'h000000, frg};
            default:        rd_hit = 1'b0;
        endcase
    end

    // APB slave, one wait-free access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            cfg     <= `USP_CFG_RST;
            ctl     <= `USP_CTL_RST;
            brg     <= `USP_BRG_RST;
            frg     <= `USP_FRG_RST;
            mask    <= {`USP_EV_W{1'b0}};
            evt     <= {`USP_EV_W{1'b0}};
            tx_buf  <= 9'h000;
            tx_full <= 1'b0;
            irq     <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_hit;
            if (psel & ~penable)
                prdata <= pwrite ? 32'h00000000 : rd_val;
            // Set wins over write-one-to-clear
            evt <= (evt & ~((wr && paddr == `USP_EVT) ? pwdata[`USP_EV_W-1:0] : {`USP_EV_W{1'b0}}))
                 | ev_set;
            irq <= |(evt & mask);
            if (tx_go)
                tx_full <= 1'b0;
            if (wr) begin
                case (paddr)
                    `USP_CFG:   cfg  <= pwdata[17:0];
                    `USP_CTL:   ctl  <= pwdata[10:0];
                    `USP_MASK:  mask <= pwdata[`USP_EV_W-1:0];
                    `USP_BRG:   brg  <= pwdata[15:0];
                    `USP_FRG:   frg  <= pwdata[7:0];
                    `USP_TXDAT: begin
                        if (!tx_full || tx_go) begin
                            tx_buf  <= pwdata[8:0];
                            tx_full <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// ==== verification/usp_serial_port_asserts.sv ====
`timescale 1ns/1ps
module usp_chk (
    input wire        pclk,    // Clock
    input wire        presetn, // Reset
    input wire [7:0]  paddr,   // Address
    input wire        psel,    // Select
    input wire        penable, // Enable
    input wire        pwrite,  // Write
    input wire [31:0] pwdata,  // Write data
    input wire        pready,  // Ready
    input wire [31:0] prdata,  // Read data
    input wire        pslverr, // Error
    input wire        txd_o,   // Serial out
    input wire        rts_n_o, // Flow out
    input wire        sclk_oe, // Clock enable
    input wire        dir_o    // Direction
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    reg  [17:0] cfg;
    reg  [10:0] ctl;
    wire        wr = psel && penable && pready && pwrite;
    // Copies of config and control words
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 18'h0;
            ctl <= 11'h0;
        end else if (wr && paddr == 8'h00) begin
            cfg <= pwdata[17:0];
        end else if (wr && paddr == 8'h04) begin
            ctl <= pwdata[10:0];
        end
    end
    property p_rdy;
        psel && !penable |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("ready held");
    property p_err;
        pready && paddr > 8'h24 |-> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_brk;
        ctl[1] && $past(ctl[1]) |-> !txd_o;
    endproperty
    a_brk: assert property (p_brk) else $error("no break");
    property p_bit;
        $fell(txd_o) && !cfg[11] && !ctl[1] |=> !txd_o [*8];
    endproperty
    a_bit: assert property (p_bit) else $error("short bit");
    property p_oe;
        $stable(cfg) |-> sclk_oe == (cfg[0] && (cfg[11] ? cfg[14] : cfg[17]));
    endproperty
    a_oe: assert property (p_oe) else $error("clock enable");
    property p_dir;
        $stable(ctl) |-> dir_o == ctl[10];
    endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_rts;
        !cfg[9] && !$past(cfg[9]) && $past(presetn, 3) |-> !rts_n_o;
    endproperty
    a_rts: assert property (p_rts) else $error("rts high");
    c_tx: cover property ($fell(txd_o));
    c_err: cover property (pready && pslverr);
    c_brk: cover property (ctl[1] && !txd_o);
endmodule
bind usp_serial_port usp_chk u_usp_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .txd_o(txd_o), .rts_n_o(rts_n_o), .sclk_oe(sclk_oe), .dir_o(dir_o)
);

// ==== verification/usp_peer.sv ====
`timescale 1ns/1ps
module usp_peer #(
    parameter BIT = 16
) (
    input  wire pclk,  // Clock
    input  wire txd,   // From port
    input  wire rts_n, // Port ready when low
    output reg  rxd,   // To port
    output reg  cts_n  // Port may send when low
);
    integer n_stall;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
        n_stall = 0;
    end
    task hold(input b, input integer n);
        begin
            rxd <= b;
            repeat (n * BIT) @(posedge pclk);
        end
    endtask
    task send(input [8:0] d, input integer nb, input integer par, input integer ns, input bad);
        integer j;
        begin
            for (j = 0; j < 9999 && rts_n; j = j + 1) @(posedge pclk);
            if (rts_n) n_stall = n_stall + 1;
            hold(1'b0, 1);
            for (j = 0; j < nb; j = j + 1) hold(d[j], 1);
            if (par != 0) hold(^d ^ (par == 3) ^ bad, 1);
            hold(1'b1, ns);
        end
    endtask
    task recv(input integer nb, input integer np, output [9:0] w, output ok);
        integer j;
        begin
            w = 10'h0;
            ok = 1'b0;
            for (j = 0; j < 9999 && txd; j = j + 1) @(posedge pclk);
            if (!txd) begin
                repeat (BIT / 2) @(posedge pclk);
                for (j = 0; j < nb + np; j = j + 1) begin
                    repeat (BIT) @(posedge pclk);
                    w[j] = txd;
                end
                repeat (BIT) @(posedge pclk);
                ok = txd;
            end
        end
    endtask
endmodule

// ==== verification/usart_serial_port_tb.sv ====
`timescale 1ns/1ps
module usart_serial_port_tb;
    reg         pclk, presetn, psel, penable, pwrite, err, ok, sk;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd;
    reg  [9:0]  w;
    reg  [8:0]  d;
    wire        pready, pslverr, rxd, txd_o, cts_n, rts_n_o, dir_o, irq, sclk, frg;
    wire [31:0] prdata;
    integer     n_fail, comparisons, k, nb, par;
    usp_serial_port u_usp_serial_port (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rxd_i(rxd), .txd_o(txd_o), .cts_n_i(cts_n), .rts_n_o(rts_n_o), .sclk_i(1'b0),
        .sclk_o(sclk), .sclk_oe(), .dir_o(dir_o), .irq(irq), .frg_tick_o(frg)
    );
    usp_peer u_usp_peer (.pclk(pclk), .txd(txd_o), .rts_n(rts_n_o), .rxd(rxd), .cts_n(cts_n));
    always #5 pclk = ~pclk;
    task give_verdict;
        begin
            $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] wd);
        integer j;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            for (j = 0; j < 16 && pready !== 1'b1; j = j + 1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
            if (pready === 1'b0 && j == 16) begin
                n_fail = n_fail + 1;
                give_verdict;
            end
        end
    endtask
    // Data bits plus the parity bit above them
    function [9:0] exp_w(input [8:0] v, input integer n, input integer p);
        begin
            exp_w = {1'b0, v};
            if (p != 0) exp_w[n] = ^v ^ (p == 3);
        end
    endfunction
    initial begin
        repeat (90000) @(posedge pclk);
        n_fail = n_fail + 1;
        give_verdict;
    end
    initial begin
        n_fail = 0;
        comparisons = 0;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rd = $urandom(34451);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h10, 32'h1);
        for (k = 0; k < 18; k = k + 1) begin
            nb = 7 + k % 3;
            par = k / 3 % 3;
            par = par + (par != 0);
            apb(1'b1, 8'h00, 1 | k % 3 << 2 | par << 4 | k / 9 << 6);
            d = 9'($urandom & ((1 << nb) - 1));
            apb(1'b1, 8'h1c, {23'h0, d});
            u_usp_peer.recv(nb, par != 0, w, ok);
            chk({21'h0, ok, w}, {22'h1, exp_w(d, nb, par)});
            chk({31'h0, irq}, 32'h0);
            d = 9'($urandom & ((1 << nb) - 1));
            u_usp_peer.send(d, nb, par, 1 + k / 9, k % 2);
            apb(1'b0, 8'h18, 32'h0);
            chk(rd & 32'he1ff, (par != 0 && k % 2) * 32'h4000 | d);
            chk({31'h0, irq}, 32'h1);
            apb(1'b1, 8'h0c, 32'h3ff);
            @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
        end
        apb(1'b1, 8'h00, 32'h5);
        u_usp_peer.send(9'h0a5, 8, 0, 1, 1'b0);
        u_usp_peer.send(9'h05a, 8, 0, 1, 1'b0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd & 32'h41, 32'h41);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd & 32'h1ff, 32'ha5);
        u_usp_peer.hold(1'b0, 12);
        u_usp_peer.hold(1'b1, 2);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd & 32'h8, 32'h8);
        apb(1'b1, 8'h04, 32'h402);
        apb(1'b0, 8'h08, 32'h0);
        chk({30'h0, txd_o, dir_o}, 32'h1);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h0c, 32'h3ff);
        apb(1'b1, 8'h00, 32'h205);
        u_usp_peer.cts_n <= 1'b1;
        apb(1'b1, 8'h1c, 32'h0);
        repeat (100) @(posedge pclk);
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, txd_o} | rd & 32'h100, 32'h101);
        u_usp_peer.cts_n <= 1'b0;
        u_usp_peer.recv(8, 0, w, ok);
        chk({21'h0, ok, w}, 32'h400);
        // Data loopback with baud clock out, break word still held
        apb(1'b1, 8'h00, 32'h28005);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd & 32'h1ff, 32'h0);
        sk = sclk;
        @(posedge pclk);
        chk({31'h0, sk ^ sclk}, 32'h1);
        chk({31'h0, frg}, 32'h1);
        apb(1'b1, 8'h04, 32'h40);
        d = 9'($urandom & 32'hff);
        apb(1'b1, 8'h1c, {23'h0, d});
        repeat (300) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd & 32'h44, 32'h40);
        apb(1'b1, 8'h04, 32'h0);
        repeat (300) @(posedge pclk);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd & 32'he1ff, {23'h0, d});
        chk(u_usp_peer.n_stall, 32'h0);
        give_verdict;
    end
endmodule
